// [core/tbt_pkg.sv]
// constants for the 10 Mb/s test and self-test control block
package tbt_pkg;
    localparam logic [4:0]  TBT_ADDR_STATCTL   = 5'h1a;
    localparam logic [4:0]  TBT_ADDR_EXT       = 5'h1b;
    localparam int          TBT_BIT_JABBER_DIS = 0;
    localparam int          TBT_BIT_HBEAT_DIS  = 1;
    localparam int          TBT_BIT_RSVD_ONE   = 2;
    localparam int          TBT_BIT_GAP        = 2;
    localparam int          TBT_BIT_PATT_ON    = 4;
    localparam int          TBT_BIT_NONSTOP    = 5;
    localparam int          TBT_TALLY_LSB      = 8;
    localparam logic [15:0] TBT_STATCTL_RESET  = 16'h0004;
    localparam logic [15:0] TBT_STATCTL_WMASK  = 16'hffef;
    localparam logic [15:0] TBT_EXT_RESET      = 16'h0000;
    localparam logic [15:0] TBT_EXT_WMASK      = 16'h00ff;
    localparam int          TBT_CLK_MHZ        = 100;
    localparam int          TBT_GAP_SHORT_US   = 10;
    localparam int          TBT_GAP_LONG_US    = 15;
    localparam int          TBT_GAP_SHORT_CYC  = TBT_GAP_SHORT_US * TBT_CLK_MHZ;
    localparam int          TBT_GAP_LONG_CYC   = TBT_GAP_LONG_US * TBT_CLK_MHZ;
    typedef enum logic [3:0] {
        TBT_PAT_EOP_FIRST  = 4'b0001,
        TBT_PAT_EOP_SECOND = 4'b0010,
        TBT_PAT_LINK_PULSE = 4'b0100,
        TBT_PAT_TONE       = 4'b1000
    } tbt_pattern_type;
endpackage

// [core/tbt_err_tally.sv]
// saturating selftest error counter
`timescale 1ns/100ps
`default_nettype none
module tbt_err_tally
    import tbt_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk_in,
    input  wire logic             arst_n_in,
    input  wire logic             clk_en_in,
    input  wire logic             restart_in,
    input  wire logic             bad_nibble_in,
    output logic      [WIDTH-1:0] tally_out
);
    logic [WIDTH-1:0] tally_q;
    logic [WIDTH-1:0] tally_d;
    // clear on restart, otherwise count and stick at maximum
    always_comb begin
        tally_d = tally_q;
        if (restart_in) begin
            tally_d = '0;
        end else if (bad_nibble_in && (tally_q != {WIDTH{1'b1}})) begin
            tally_d = tally_q + 1'b1;
        end
    end
    // register the tally
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tally_q <= '0;
        end else if (clk_en_in) begin
            tally_q <= tally_d;
        end
    end
    assign tally_out = tally_q;
    chk_tally_sticks: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && !restart_in && tally_q == {WIDTH{1'b1}}) |=> tally_q == {WIDTH{1'b1}})
        else $error("tally left its maximum");
    chk_tally_clears: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && restart_in) |=> tally_q == '0)
        else $error("tally not cleared on restart");
    chk_tally_counts: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && !restart_in && bad_nibble_in && tally_q != {WIDTH{1'b1}})
        |=> tally_q == $past(tally_q) + 1'b1)
        else $error("tally missed an errored nibble");
    cov_tally_full: cover property (@(posedge mclk_in) tally_q == {WIDTH{1'b1}});
endmodule
`default_nettype wire

// [core/tbt_gap_timer.sv]
// idle gap timer between test sequences
`timescale 1ns/100ps
`default_nettype none
module tbt_gap_timer
    import tbt_pkg::*;
#(
    parameter int SHORT_CYC = TBT_GAP_SHORT_CYC,
    parameter int LONG_CYC  = TBT_GAP_LONG_CYC
) (
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    input  wire logic clk_en_in,
    input  wire logic start_in,
    input  wire logic long_in,
    output logic      busy_out
);
    logic [15:0] left_q;
    logic [15:0] left_d;
    // load on start, then count down to zero
    always_comb begin
        left_d = left_q;
        if (start_in) begin
            left_d = long_in ? 16'(LONG_CYC) : 16'(SHORT_CYC);
        end else if (left_q != 16'h0000) begin
            left_d = left_q - 16'h0001;
        end
    end
    // register the count
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            left_q <= 16'h0000;
        end else if (clk_en_in) begin
            left_q <= left_d;
        end
    end
    assign busy_out = (left_q != 16'h0000);
    chk_gap_load: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && start_in) |=> left_q == (long_in ? 16'(LONG_CYC) : 16'(SHORT_CYC)))
        else $error("gap length wrong");
endmodule
`default_nettype wire

// [core/tbt_ctrl.sv]
// 10 Mb/s test, heartbeat, jabber and selftest extension register block
`timescale 1ns/100ps
`default_nettype none
module tbt_ctrl
    import tbt_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        arst_n_in,
    input  wire logic        clk_en_in,
    input  wire logic [4:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    input  wire logic        speed_100_in,
    input  wire logic        full_duplex_in,
    input  wire logic        selftest_start_in,
    input  wire logic        bad_nibble_in,
    input  wire logic        tx_seq_done_in,
    output logic             heartbeat_en_out,
    output logic             jabber_en_out,
    output logic             selftest_nonstop_tx_out,
    output logic             ten_meg_pattern_on_out,
    output logic             gap_idle_out,
    output logic      [3:0]  pattern_sel_out
);
    logic [15:0]     statctl_q;
    logic [15:0]     statctl_d;
    logic [15:0]     ext_q;
    logic [15:0]     ext_d;
    logic [15:0]     rdata_q;
    logic [15:0]     rdata_d;
    logic [7:0]      tally;
    logic            gap_busy;
    logic [3:0]      pat_d;
    logic [3:0]      pat_q;
    logic            hb_q;
    logic            hb_d;
    logic            jab_q;
    logic            jab_d;

    // software writes to the two control registers
    always_comb begin
        statctl_d = statctl_q;
        ext_d     = ext_q;
        if (reg_wr_in && reg_addr_in == TBT_ADDR_STATCTL) begin
            statctl_d = reg_wdata_in & TBT_STATCTL_WMASK;
        end else if (reg_wr_in && reg_addr_in == TBT_ADDR_EXT) begin
            ext_d = reg_wdata_in & TBT_EXT_WMASK;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd_in && reg_addr_in == TBT_ADDR_STATCTL) begin
            rdata_d = statctl_q;
        end else if (reg_rd_in && reg_addr_in == TBT_ADDR_EXT) begin
            rdata_d = {tally, ext_q[7:0]};
        end
    end

    // heartbeat and jabber enables from mode and control bits
    always_comb begin
        hb_d  = !speed_100_in && !full_duplex_in && !statctl_q[TBT_BIT_HBEAT_DIS];
        jab_d = !speed_100_in && !statctl_q[TBT_BIT_JABBER_DIS];
    end

    // decode the pattern choice, nothing selected while the pattern is off
    always_comb begin
        pat_d = 4'h0;
        if (ext_q[TBT_BIT_PATT_ON]) begin
            case (ext_q[1:0])
                2'b00: begin
                    pat_d = TBT_PAT_EOP_FIRST;
                end
                2'b01: begin
                    pat_d = TBT_PAT_EOP_SECOND;
                end
                2'b10: begin
                    pat_d = TBT_PAT_LINK_PULSE;
                end
                default: begin
                    pat_d = TBT_PAT_TONE;
                end
            endcase
        end
    end

    // register the two control registers
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            statctl_q <= TBT_STATCTL_RESET;
            ext_q     <= TBT_EXT_RESET;
        end else if (clk_en_in) begin
            statctl_q <= statctl_d;
            ext_q     <= ext_d;
        end
    end

    // register the read data, one cycle after the strobe
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 16'h0000;
        end else if (clk_en_in) begin
            rdata_q <= rdata_d;
        end
    end

    // register the heartbeat and jabber enables
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hb_q  <= 1'b0;
            jab_q <= 1'b0;
        end else if (clk_en_in) begin
            hb_q  <= hb_d;
            jab_q <= jab_d;
        end
    end

    // register the pattern select
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pat_q <= 4'h0;
        end else if (clk_en_in) begin
            pat_q <= pat_d;
        end
    end

    tbt_err_tally #(
        .WIDTH(8)
    ) u_tally (
        .mclk_in      (mclk_in),
        .arst_n_in    (arst_n_in),
        .clk_en_in    (clk_en_in),
        .restart_in   (selftest_start_in),
        .bad_nibble_in(bad_nibble_in),
        .tally_out    (tally)
    );

    tbt_gap_timer u_gap (
        .mclk_in  (mclk_in),
        .arst_n_in(arst_n_in),
        .clk_en_in(clk_en_in),
        .start_in (tx_seq_done_in && ext_q[TBT_BIT_PATT_ON] && !ext_q[TBT_BIT_NONSTOP]),
        .long_in  (ext_q[TBT_BIT_GAP]),
        .busy_out (gap_busy)
    );

    // outputs
    assign reg_rdata_out           = rdata_q;
    assign heartbeat_en_out        = hb_q;
    assign jabber_en_out           = jab_q;
    assign selftest_nonstop_tx_out = ext_q[TBT_BIT_NONSTOP];
    assign ten_meg_pattern_on_out  = ext_q[TBT_BIT_PATT_ON];
    assign gap_idle_out            = gap_busy;
    assign pattern_sel_out         = pat_q;

    chk_hbeat_fast_off: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && (speed_100_in || full_duplex_in)) |=> !heartbeat_en_out)
        else $error("heartbeat on at 100M or full duplex");
    chk_hbeat_dis_bit: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && !speed_100_in && !full_duplex_in)
        |=> heartbeat_en_out == !$past(statctl_q[TBT_BIT_HBEAT_DIS]))
        else $error("heartbeat does not follow its disable bit");
    chk_jabber_dis: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && statctl_q[TBT_BIT_JABBER_DIS]) |=> !jabber_en_out)
        else $error("jabber on while disabled");
    chk_ext_readback: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_rd_in && reg_addr_in == TBT_ADDR_EXT)
        |=> reg_rdata_out[15:8] == $past(tally))
        else $error("tally not in read bits 15:8");
    chk_nonstop_bit: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_wr_in && reg_addr_in == TBT_ADDR_EXT)
        |=> selftest_nonstop_tx_out == $past(reg_wdata_in[TBT_BIT_NONSTOP]))
        else $error("continuous mode bit not applied");
    chk_pattern_off: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && !ext_q[TBT_BIT_PATT_ON]) |=> pattern_sel_out == 4'h0)
        else $error("pattern selected while disabled");
    chk_pattern_tone: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && ext_q[TBT_BIT_PATT_ON] && ext_q[1:0] == 2'b11)
        |=> pattern_sel_out == TBT_PAT_TONE)
        else $error("tone pattern not selected");
    chk_gap_after_seq: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && tx_seq_done_in && ext_q[TBT_BIT_PATT_ON] && !ext_q[TBT_BIT_NONSTOP])
        |=> gap_idle_out)
        else $error("no gap after test sequence");
    // jabber stays on at 10M while its disable bit is clear
    chk_jabber_on: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && !speed_100_in && !statctl_q[TBT_BIT_JABBER_DIS]) |=> jabber_en_out)
        else $error("jabber off while enabled");
    // the three other pattern choices
    chk_pattern_first: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && ext_q[TBT_BIT_PATT_ON] && ext_q[1:0] == 2'b00)
        |=> pattern_sel_out == TBT_PAT_EOP_FIRST)
        else $error("first eop pattern not selected");
    chk_pattern_second: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && ext_q[TBT_BIT_PATT_ON] && ext_q[1:0] == 2'b01)
        |=> pattern_sel_out == TBT_PAT_EOP_SECOND)
        else $error("second eop pattern not selected");
    chk_pattern_pulse: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && ext_q[TBT_BIT_PATT_ON] && ext_q[1:0] == 2'b10)
        |=> pattern_sel_out == TBT_PAT_LINK_PULSE)
        else $error("link pulse pattern not selected");
    // pattern enable bit follows a write
    chk_patt_on_bit: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && reg_wr_in && reg_addr_in == TBT_ADDR_EXT)
        |=> ten_meg_pattern_on_out == $past(reg_wdata_in[TBT_BIT_PATT_ON]))
        else $error("pattern enable bit not applied");
    // read data stands only in the cycle after a read
    chk_rdata_idle: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
        (clk_en_in && !reg_rd_in) |=> reg_rdata_out == 16'h0000)
        else $error("read data outside read cycle");
    cov_tone: cover property (@(posedge mclk_in) pattern_sel_out == TBT_PAT_TONE);
    cov_nonstop: cover property (@(posedge mclk_in) selftest_nonstop_tx_out && !jabber_en_out);
    cov_long_gap: cover property (@(posedge mclk_in) gap_idle_out && ext_q[TBT_BIT_GAP]);
endmodule
`default_nettype wire

// [verif/tbt_ctrl_tb.sv]
// self-checking bench for the 10 Mb/s test and selftest control block
`timescale 1ns/100ps
`default_nettype none
module tbt_ctrl_tb
    import tbt_pkg::*;
;
    logic        mclk_in;
    logic        arst_n_in;
    logic        en;
    logic [4:0]  addr;
    logic [15:0] wd;
    logic        wr_s;
    logic        rd_s;
    logic        sp;
    logic        fd;
    logic        st;
    logic        bn;
    logic        dn;
    logic [15:0] rdata;
    logic        hb;
    logic        jb;
    logic        ns;
    logic        po;
    logic        gi;
    logic [3:0]  ps;
    logic [15:0] v;
    int          n_errors;
    int          tests_run;

    tbt_ctrl u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .clk_en_in(en),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata), .speed_100_in(sp), .full_duplex_in(fd),
        .selftest_start_in(st), .bad_nibble_in(bn), .tx_seq_done_in(dn),
        .heartbeat_en_out(hb), .jabber_en_out(jb), .selftest_nonstop_tx_out(ns),
        .ten_meg_pattern_on_out(po), .gap_idle_out(gi), .pattern_sel_out(ps));

    // 100 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        wd   <= d;
        wr_s <= 1'b1;
        @(posedge mclk_in);
        wr_s <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk_in);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk_in);
        #1;
    endtask

    task automatic t_reset();
        rd(TBT_ADDR_STATCTL, v); chk("statctl reset", 16'h0004, v);
        rd(TBT_ADDR_EXT, v); chk("ext reset", 16'h0000, v);
        rd(5'h05, v); chk("unmapped read", 16'h0000, v);
        chk("heartbeat", 16'h0001, {15'h0000, hb});
        chk("jabber", 16'h0001, {15'h0000, jb});
        chk("pattern sel", 16'h0000, {12'h000, ps});
        $display("test reset done");
    endtask

    task automatic t_hbjab();
        wr(TBT_ADDR_STATCTL, 16'h0007); settle();
        chk("heartbeat off", 16'h0000, {15'h0000, hb});
        chk("jabber off", 16'h0000, {15'h0000, jb});
        wr(TBT_ADDR_STATCTL, 16'h0014); rd(TBT_ADDR_STATCTL, v);
        chk("statctl bit4 fixed", 16'h0004, v);
        settle();
        chk("heartbeat on", 16'h0001, {15'h0000, hb});
        fd <= 1'b1; settle();
        chk("heartbeat fdx", 16'h0000, {15'h0000, hb});
        chk("jabber fdx", 16'h0001, {15'h0000, jb});
        fd <= 1'b0; sp <= 1'b1; settle();
        chk("heartbeat 100m", 16'h0000, {15'h0000, hb});
        chk("jabber 100m", 16'h0000, {15'h0000, jb});
        sp <= 1'b0;
        $display("test heartbeat jabber done");
    endtask

    task automatic t_patt();
        for (int i = 0; i < 4; i++) begin
            wr(TBT_ADDR_EXT, 16'h0010 | 16'(i)); settle();
            chk("pattern sel", 16'(1 << i), {12'h000, ps});
            chk("pattern on", 16'h0001, {15'h0000, po});
        end
        wr(TBT_ADDR_EXT, 16'hff23); settle();
        chk("pattern off sel", 16'h0000, {12'h000, ps});
        chk("pattern off", 16'h0000, {15'h0000, po});
        chk("nonstop", 16'h0001, {15'h0000, ns});
        rd(TBT_ADDR_EXT, v); chk("tally read only", 16'h0023, v);
        // writes with the clock enable low must not land
        en <= 1'b0; wr(TBT_ADDR_EXT, 16'h0010); en <= 1'b1; settle();
        chk("frozen write", 16'h0000, {15'h0000, po});
        wr(TBT_ADDR_EXT, 16'h0000);
        $display("test pattern done");
    endtask

    task automatic t_tally();
        @(posedge mclk_in); st <= 1'b1;
        @(posedge mclk_in); st <= 1'b0; bn <= 1'b1;
        repeat (3) @(posedge mclk_in);
        bn <= 1'b0; settle();
        rd(TBT_ADDR_EXT, v); chk("tally three", 16'h0300, v);
        @(posedge mclk_in); bn <= 1'b1;
        repeat (300) @(posedge mclk_in);
        bn <= 1'b0; settle();
        rd(TBT_ADDR_EXT, v); chk("tally saturated", 16'hff00, v);
        @(posedge mclk_in); st <= 1'b1; bn <= 1'b1;
        @(posedge mclk_in); st <= 1'b0; bn <= 1'b0; settle();
        rd(TBT_ADDR_EXT, v); chk("tally restart", 16'h0000, v);
        $display("test tally done");
    endtask

    // counts idle-gap cycles after one sequence end in a fixed window
    task automatic gap_run(input logic [15:0] cfg, input int exp);
        int cnt;
        cnt = 0;
        wr(TBT_ADDR_EXT, cfg); settle();
        @(posedge mclk_in); dn <= 1'b1;
        @(posedge mclk_in); dn <= 1'b0;
        for (int k = 0; k < 1700; k++) begin
            #1;
            if (gi === 1'b1) cnt++;
            @(posedge mclk_in);
        end
        chk("gap cycles", 16'(exp), 16'(cnt));
    endtask

    task automatic t_gap();
        gap_run(16'h0010, TBT_GAP_SHORT_CYC);
        gap_run(16'h0014, TBT_GAP_LONG_CYC);
        wr(TBT_ADDR_STATCTL, 16'h0005); settle();
        chk("jabber before nonstop", 16'h0000, {15'h0000, jb});
        gap_run(16'h0030, 0);
        $display("test gap done");
    endtask

    // hang guard
    initial begin
        #1ms;
        n_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        end_sim();
    end

    initial begin
        n_errors = 0; tests_run = 0;
        arst_n_in = 1'b0; en = 1'b1; addr = 5'h00; wd = 16'h0000;
        wr_s = 1'b0; rd_s = 1'b0; sp = 1'b0; fd = 1'b0;
        st = 1'b0; bn = 1'b0; dn = 1'b0;
        repeat (16) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        settle();
        t_reset();
        t_hbjab();
        t_patt();
        t_tally();
        t_gap();
        end_sim();
    end
endmodule
`default_nettype wire
